//--- gpd_port.sv
// Purpose: data storage, drive decode and pin read for two eight-pin ports
// Assumes: cpu strobes on mclk_in; pins are asynchronous
// Notes: reads return synchronised pin levels, zero for analog-mode pins, two cycles behind the pad
`timescale 1ns/1ps
`include "gpd_params.svh"
module gpd_port (
    // clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 nrst_in,
    // cpu side
    input  wire gpd_pkg::gpd_cpu_t    cpu_in,
    input  wire gpd_pkg::gpd_cfg_t    cfg0_in,
    input  wire gpd_pkg::gpd_cfg_t    cfg1_in,
    input  wire logic [7:0]           pin_config_reg_in,
    input  wire logic [7:0]           serial_en_in,
    input  wire logic [7:0]           byp_data0_in,
    input  wire logic [7:0]           byp_data1_in,
    output logic [7:0]                rdata_out,
    output logic [1:0]                reg_level_out,
    // pins
    input  wire logic [7:0]           pad0_in,
    input  wire logic [7:0]           pad1_in,
    output gpd_pkg::gpd_drive_t       drive0_out,
    output gpd_pkg::gpd_drive_t       drive1_out,
    output logic [7:0]                in_en0_out,
    output logic [7:0]                in_en1_out
);
    import gpd_pkg::*;

    logic [7:0] port_pin_data [`GPD_PORTS];
    gpd_cfg_t   cfg_q [`GPD_PORTS];
    logic       reg_en;
    logic [7:0] sync1 [`GPD_PORTS];
    logic [7:0] sync2 [`GPD_PORTS];
    logic [7:0] in_en_q [`GPD_PORTS];
    gpd_drive_t next_drive [`GPD_PORTS];
    logic [7:0] next_in_en [`GPD_PORTS];

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            port_pin_data[0] <= `GPD_RST_BYTE;
            port_pin_data[1] <= `GPD_RST_BYTE;
        end else if (cpu_in.wr) begin
            port_pin_data[cpu_in.port] <= cpu_in.wdata;
        end
    end

    // configuration captured so every pin output is from a flop
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_q[0] <= '0;
            cfg_q[1] <= '0;
            reg_en   <= 1'b0;
            reg_level_out <= `GPD_LVL_3V0;
        end else begin
            cfg_q[0] <= cfg0_in;
            cfg_q[1] <= cfg1_in;
            reg_en   <= pin_config_reg_in[`GPD_CFG_REG_EN];
            // reserved code falls back to the highest level
            if (pin_config_reg_in[`GPD_CFG_LVL_HI:`GPD_CFG_LVL_LO] == `GPD_LVL_RSVD) begin
                reg_level_out <= `GPD_LVL_3V0;
            end else begin
                reg_level_out <= pin_config_reg_in[`GPD_CFG_LVL_HI:`GPD_CFG_LVL_LO];
            end
        end
    end

    // pad levels cross in via two flops
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1[0] <= `GPD_RST_BYTE;
            sync1[1] <= `GPD_RST_BYTE;
            sync2[0] <= `GPD_RST_BYTE;
            sync2[1] <= `GPD_RST_BYTE;
        end else begin
            sync1[0] <= pad0_in;
            sync1[1] <= pad1_in;
            sync2[0] <= sync1[0];
            sync2[1] <= sync1[1];
        end
    end

    // analog mode pins read zero since their buffer is off
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= `GPD_RST_BYTE;
        end else if (cpu_in.rd) begin
            rdata_out <= sync2[cpu_in.port] & in_en_q[cpu_in.port];
        end
    end

    genvar p;
    genvar i;
    generate
        for (p = 0; p < `GPD_PORTS; p++) begin : g_port
            for (i = 0; i < `GPD_PINS; i++) begin : g_pin
                logic byp;
                logic bdat;
                assign byp  = cfg_q[p].bypass_select_reg[i] | serial_en_in[i];
                assign bdat = (p == 0) ? byp_data0_in[i] : byp_data1_in[i];
                gpd_pin u_pin (
                    .mode_in      ({cfg_q[p].drive_mode_high_bit[i],
                                    cfg_q[p].drive_mode_low_bit[i]}),
                    .data_in      (port_pin_data[p][i]),
                    .byp_sel_in   ((p == 0) ? 1'b0 : byp),
                    .byp_data_in  (bdat),
                    .reg_en_in    ((p == 1) ? reg_en : 1'b0),
                    .drv_low_out  (next_drive[p].drv_low[i]),
                    .drv_high_out (next_drive[p].drv_high[i]),
                    .pull_up_out  (next_drive[p].pull_up[i]),
                    .reg_high_out (next_drive[p].reg_high[i]),
                    .in_en_out    (next_in_en[p][i])
                );
            end
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            drive0_out <= '0;
            drive1_out <= '0;
            in_en_q[0] <= `GPD_RST_IN_EN;
            in_en_q[1] <= `GPD_RST_IN_EN;
        end else begin
            drive0_out <= next_drive[0];
            drive1_out <= next_drive[1];
            in_en_q[0] <= next_in_en[0];
            in_en_q[1] <= next_in_en[1];
        end
    end
    assign in_en0_out = in_en_q[0];
    assign in_en1_out = in_en_q[1];

    // views of single pins, read only by the checks below
    logic [1:0] chk_m0p1;
    logic [1:0] chk_m1p0;
    logic [1:0] chk_m1p1;
    logic [1:0] chk_m1p7;
    logic       chk_b1p0;
    assign chk_m0p1 = {cfg_q[0].drive_mode_high_bit[1], cfg_q[0].drive_mode_low_bit[1]};
    assign chk_m1p0 = {cfg_q[1].drive_mode_high_bit[0], cfg_q[1].drive_mode_low_bit[0]};
    assign chk_m1p1 = {cfg_q[1].drive_mode_high_bit[1], cfg_q[1].drive_mode_low_bit[1]};
    assign chk_m1p7 = {cfg_q[1].drive_mode_high_bit[7], cfg_q[1].drive_mode_low_bit[7]};
    assign chk_b1p0 = cfg_q[1].bypass_select_reg[0] | serial_en_in[0];

    // storage and read path
    write_latch_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        cpu_in.wr |=> port_pin_data[$past(cpu_in.port)] == $past(cpu_in.wdata))
        else $error("port data not latched");
    write_other_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        cpu_in.wr |=> port_pin_data[~$past(cpu_in.port)] == $past(port_pin_data[~cpu_in.port]))
        else $error("other port data disturbed");
    read_pins_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        cpu_in.rd |=> rdata_out == ($past(sync2[cpu_in.port]) & $past(in_en_q[cpu_in.port])))
        else $error("read not pin level");

    // input buffer enables, one cycle behind the captured mode
    analog_off_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m1p0) == `GPD_DM_HIZ_ANA |-> !in_en1_out[0])
        else $error("analog input left on");
    digital_on_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m1p0) != `GPD_DM_HIZ_ANA |-> in_en1_out[0])
        else $error("digital input switched off");

    // drive decode per mode, no bypass
    strong_follow_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m1p0) == `GPD_DM_STRONG && !$past(chk_b1p0)
        |-> drive1_out.drv_high[0] == $past(port_pin_data[1][0])
            && drive1_out.drv_low[0] != $past(port_pin_data[1][0]))
        else $error("strong drive not following data");
    pullup_in_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m1p0) == `GPD_DM_RES_HIGH && $past(port_pin_data[1][0])
        && !$past(chk_b1p0)
        |-> drive1_out.pull_up[0] && !drive1_out.drv_low[0] && !drive1_out.drv_high[0])
        else $error("pull-up input not formed");
    od_release_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m1p0) == `GPD_DM_OPEN_DRN && $past(port_pin_data[1][0])
        && !$past(chk_b1p0)
        |-> !drive1_out.drv_low[0] && !drive1_out.drv_high[0] && !drive1_out.pull_up[0])
        else $error("open drain not released");
    hiz_no_drive_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m1p0) == `GPD_DM_HIZ_ANA
        |-> !drive1_out.drv_low[0] && !drive1_out.drv_high[0] && !drive1_out.pull_up[0])
        else $error("analog pin driven");
    drive_excl_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (drive1_out.drv_low & (drive1_out.drv_high | drive1_out.pull_up)) == 8'h00)
        else $error("pin driven both ways");

    // regulated high level
    reg_gate_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !$past(reg_en) |-> drive1_out.reg_high == 8'h00)
        else $error("regulated high without enable");
    reg_drive_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(reg_en) && drive1_out.drv_high[0] |-> drive1_out.reg_high[0])
        else $error("strong high not regulated");
    reg_strong_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (drive1_out.reg_high & ~drive1_out.drv_high) == 8'h00)
        else $error("regulated level outside strong high");
    res_supply_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (drive1_out.pull_up & drive1_out.reg_high) == 8'h00)
        else $error("pull-up used regulated level");
    port0_no_reg_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        drive0_out.reg_high == 8'h00)
        else $error("port 0 drove regulated high");

    // level select
    level_sel_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        pin_config_reg_in[`GPD_CFG_LVL_HI:`GPD_CFG_LVL_LO] != `GPD_LVL_RSVD
        |=> reg_level_out == $past(pin_config_reg_in[`GPD_CFG_LVL_HI:`GPD_CFG_LVL_LO]))
        else $error("level select not followed");
    level_rsvd_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        pin_config_reg_in[`GPD_CFG_LVL_HI:`GPD_CFG_LVL_LO] == `GPD_LVL_RSVD
        |=> reg_level_out == `GPD_LVL_3V0)
        else $error("reserved code not mapped");
    reg_level_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_level_out != `GPD_LVL_RSVD)
        else $error("reserved level driven");

    // bypass paths; port 0 has none
    bypass_reg_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m1p7) == `GPD_DM_STRONG && $past(cfg_q[1].bypass_select_reg[7])
        |-> drive1_out.drv_high[7] == $past(byp_data1_in[7]))
        else $error("bypass data not driven");
    bypass_serial_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m1p1) == `GPD_DM_STRONG && $past(serial_en_in[1])
        |-> drive1_out.drv_high[1] == $past(byp_data1_in[1]))
        else $error("serial bypass not driven");
    port0_data_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $past(chk_m0p1) == `GPD_DM_STRONG
        |-> drive0_out.drv_high[1] == $past(port_pin_data[0][1]))
        else $error("port 0 not following data");
endmodule

//--- gpd_params.svh
// Purpose: constants for the port data and drive block
// Assumes: two ports of eight pins, port 0 and port 1
// Notes: drive-mode codes are {high bit, low bit}
`ifndef GPD_PARAMS_SVH
`define GPD_PARAMS_SVH
`define GPD_PINS        8
`define GPD_PORTS       2
`define GPD_DM_RES_HIGH 2'h0
`define GPD_DM_STRONG   2'h1
`define GPD_DM_HIZ_ANA  2'h2
`define GPD_DM_OPEN_DRN 2'h3
`define GPD_CFG_REG_EN  0
`define GPD_CFG_LVL_LO  4
`define GPD_CFG_LVL_HI  5
`define GPD_LVL_3V0     2'h0
`define GPD_LVL_2V5     2'h1
`define GPD_LVL_1V8     2'h2
`define GPD_LVL_RSVD    2'h3
`define GPD_RST_BYTE    8'h00
`define GPD_RST_CFG     8'h00
`define GPD_RST_IN_EN   8'hFF
`endif

//--- gpd_pkg.sv
// Purpose: types for the port data and drive block
// Assumes: two ports
// Notes: none
package gpd_pkg;
    typedef enum logic [1:0] {
        GPD_HIGH_SUPPLY,
        GPD_HIGH_REG,
        GPD_HIGH_RES,
        GPD_HIGH_NONE
    } gpd_high_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       port;
        logic [7:0] wdata;
    } gpd_cpu_t;
    typedef struct packed {
        logic [7:0] drive_mode_high_bit;
        logic [7:0] drive_mode_low_bit;
        logic [7:0] bypass_select_reg;
    } gpd_cfg_t;
    typedef struct packed {
        logic [7:0] drv_low;
        logic [7:0] drv_high;
        logic [7:0] pull_up;
        logic [7:0] reg_high;
    } gpd_drive_t;
endpackage

//--- gpd_pin.sv
// Purpose: one pin's driver decode
// Assumes: mode and data inputs are registered in the top; bypass data and serial enable arrive unregistered
// Notes: pull_up means weak resistive high, always to chip supply
`timescale 1ns/1ps
`include "gpd_params.svh"
module gpd_pin (
    // control
    input  wire logic [1:0] mode_in,
    input  wire logic       data_in,
    input  wire logic       byp_sel_in,
    input  wire logic       byp_data_in,
    input  wire logic       reg_en_in,
    // pin control
    output logic            drv_low_out,
    output logic            drv_high_out,
    output logic            pull_up_out,
    output logic            reg_high_out,
    output logic            in_en_out
);
    logic bit_val;
    always_comb begin
        bit_val      = byp_sel_in ? byp_data_in : data_in;
        drv_low_out  = 1'b0;
        drv_high_out = 1'b0;
        pull_up_out  = 1'b0;
        reg_high_out = 1'b0;
        unique case (mode_in)
            `GPD_DM_RES_HIGH: begin
                drv_low_out = !bit_val;
                pull_up_out = bit_val;
            end
            `GPD_DM_STRONG: begin
                drv_low_out  = !bit_val;
                drv_high_out = bit_val;
                reg_high_out = bit_val && reg_en_in;
            end
            `GPD_DM_HIZ_ANA: begin
            end
            `GPD_DM_OPEN_DRN: begin
                drv_low_out = !bit_val;
            end
        endcase
        in_en_out = (mode_in != `GPD_DM_HIZ_ANA);
    end
endmodule

//--- gpd_pad_model.sv
// Purpose: board pins and loads for one eight-pin port
// Assumes: strong drive beats the load, the load beats the pull-up
// Notes: an undriven pin toggles each cycle so a floating read shows
`timescale 1ns/1ps
module gpd_pad_model (
    // clock
    input  wire logic                mclk_in,
    // device side
    input  wire gpd_pkg::gpd_drive_t drive_in,
    // board side
    input  wire logic [7:0]          ext_en_in,
    input  wire logic [7:0]          ext_val_in,
    output logic [7:0]               pad_out
);
    import gpd_pkg::*;
    logic [7:0] flt;
    logic [7:0] act;
    initial flt = 8'h55;
    // plain always: the start value comes from the initial block
    always @(posedge mclk_in) begin
        flt <= ~flt;
    end
    assign act = drive_in.drv_low | drive_in.drv_high;
    assign pad_out = (act & drive_in.drv_high) | (~act & ext_en_in & ext_val_in)
                   | (~act & ~ext_en_in & (drive_in.pull_up | flt));
endmodule

//--- tb_top.sv
// Purpose: self-checking bench for the two-port data and drive block
// Assumes: inputs change on the falling edge
// Notes: drive settles two edges after a change, reads lag the pad
`timescale 1ns/1ps
module tb_top;
    import gpd_pkg::*;
    logic       mclk_in, nrst_in;
    gpd_cpu_t   cpu_in;
    gpd_cfg_t   cfg0, cfg1;
    gpd_drive_t drv0, drv1;
    logic [7:0] pcr, ser, byp1, e0_en, e0_v, e1_en, e1_v, pad0, pad1;
    logic [7:0] rdata, ien0, ien1, v;
    logic [1:0] lvl;
    int         fails, cmp_count;

    gpd_port i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .cpu_in(cpu_in),
        .cfg0_in(cfg0), .cfg1_in(cfg1), .pin_config_reg_in(pcr), .serial_en_in(ser),
        .byp_data0_in(8'hFF), .byp_data1_in(byp1), .rdata_out(rdata),
        .reg_level_out(lvl), .pad0_in(pad0), .pad1_in(pad1), .drive0_out(drv0),
        .drive1_out(drv1), .in_en0_out(ien0), .in_en1_out(ien1));
    gpd_pad_model i_pad0 (.mclk_in(mclk_in), .drive_in(drv0), .ext_en_in(e0_en),
        .ext_val_in(e0_v), .pad_out(pad0));
    gpd_pad_model i_pad1 (.mclk_in(mclk_in), .drive_in(drv1), .ext_en_in(e1_en),
        .ext_val_in(e1_v), .pad_out(pad1));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic settle();
        repeat (6) @(negedge mclk_in);
    endtask

    task automatic wr(logic p, logic [7:0] d);
        @(negedge mclk_in);
        cpu_in = '{wr: 1'b1, rd: 1'b0, port: p, wdata: d};
        @(negedge mclk_in);
        cpu_in.wr = 1'b0;
        settle();
    endtask

    task automatic rd(logic p, output logic [7:0] d);
        @(negedge mclk_in);
        cpu_in.rd = 1'b1;
        cpu_in.port = p;
        @(negedge mclk_in);
        cpu_in.rd = 1'b0;
        @(negedge mclk_in);
        d = rdata;
    endtask

    task automatic t_reset();
        chk8("drv_low0", 8'hFF, drv0.drv_low);
        chk8("drv_low1", 8'hFF, drv1.drv_low);
        chk8("in_en0", 8'hFF, ien0);
        chk8("level", 8'h00, {6'h0, lvl});
    endtask

    task automatic t_strong0();
        pcr = 8'h21;
        cfg0 = '{drive_mode_high_bit: 8'h00, drive_mode_low_bit: 8'hFF, bypass_select_reg: 8'h00};
        wr(1'b0, 8'hA5);
        chk8("drv_high0", 8'hA5, drv0.drv_high);
        chk8("drv_low0", 8'h5A, drv0.drv_low);
        chk8("reg_high0", 8'h00, drv0.reg_high);
        rd(1'b0, v);
        chk8("read0", 8'hA5, v);
    endtask

    task automatic t_rmw();
        pcr = 8'h01;
        e1_en = 8'h80;
        e1_v = 8'h00;
        wr(1'b1, 8'hFF);
        chk8("pull_up1", 8'hFF, drv1.pull_up);
        chk8("reg_high1", 8'h00, drv1.reg_high);
        rd(1'b1, v);
        chk8("read1", 8'h7F, v);
        wr(1'b1, v & 8'h7F);
        chk8("drv_low1", 8'h80, drv1.drv_low);
        e1_en = 8'h00;
    endtask

    task automatic t_modes();
        cfg1 = '{drive_mode_high_bit: 8'hFF, drive_mode_low_bit: 8'h00, bypass_select_reg: 8'h00};
        settle();
        chk8("in_en1", 8'h00, ien1);
        rd(1'b1, v);
        chk8("read1", 8'h00, v);
        cfg1.drive_mode_low_bit = 8'hFF;
        e1_en = 8'hFF;
        e1_v = 8'h3C;
        wr(1'b1, 8'hFF);
        chk8("drv_low1", 8'h00, drv1.drv_low);
        chk8("pull_up1", 8'h00, drv1.pull_up);
        chk8("in_en1", 8'hFF, ien1);
        rd(1'b1, v);
        chk8("read1", 8'h3C, v);
        e1_en = 8'h00;
    endtask

    task automatic t_reg();
        cfg1 = '{drive_mode_high_bit: 8'h00, drive_mode_low_bit: 8'hFF, bypass_select_reg: 8'h00};
        wr(1'b1, 8'h0F);
        for (int l = 0; l < 4; l++) begin
            pcr = {2'h0, l[1:0], 4'h1};
            settle();
            chk8("level", (l == 3) ? 8'h00 : 8'(l), {6'h0, lvl});
            chk8("reg_high1", 8'h0F, drv1.reg_high);
        end
        pcr = 8'h00;
        settle();
        chk8("reg_high1", 8'h00, drv1.reg_high);
        chk8("drv_high1", 8'h0F, drv1.drv_high);
    endtask

    task automatic t_byp();
        cfg1.bypass_select_reg = 8'hF0;
        byp1 = 8'hAA;
        wr(1'b1, 8'h00);
        chk8("drv_high1", 8'hA0, drv1.drv_high);
        ser = 8'h0F;
        settle();
        chk8("drv_high1", 8'hAA, drv1.drv_high);
        chk8("drv_high0", 8'hA5, drv0.drv_high);
    endtask

    task automatic t_rst_mid();
        @(negedge mclk_in);
        nrst_in = 1'b0;
        @(negedge mclk_in);
        chk8("drv_high0", 8'h00, drv0.drv_high);
        nrst_in = 1'b1;
        settle();
        chk8("drv_low0", 8'hFF, drv0.drv_low);
        chk8("drv_high1", 8'hAA, drv1.drv_high);
    endtask

    initial begin
        fails = 0;
        cmp_count = 0;
        nrst_in = 1'b0;
        cpu_in = '0;
        cfg0 = '0;
        cfg1 = '0;
        {pcr, ser, byp1, e0_en, e0_v, e1_en, e1_v} = '0;
        repeat (5) @(negedge mclk_in);
        nrst_in = 1'b1;
        settle();
        t_reset();
        t_strong0();
        t_rmw();
        t_modes();
        t_reg();
        t_byp();
        t_rst_mid();
        finish_test();
    end

    initial begin
        #(40 * 3000);
        fails++;
        finish_test();
    end
endmodule
